// ### hw/dma_page_map_decode.sv
// Program page registers and DMA map decoding behind an AHB-Lite slave
// Function
// - Two 16-bit page registers hold a 7-bit page each in their low bits.
// - Source page extends source addresses, destination page destination.
// - Reset clears both page registers to zero.
// - Upper bits of both page registers read as zero.
// - One page pair serves every channel.
// - Address stepping never changes the page values.
// - Stepping past a page edge wraps within the same page.
// - Number of supported pages is a parameter, at most 128.
// - Accesses to reserved regions are refused.
// - Decoding ignores the mode, data-ROM and overlay bits.
// - Internal-only variant blocks program and I/O space.
// - Internal-only variant allows serial ports, scratchpad and DARAM.
// - External variant maps data 0060-7FFF on chip, 8000 up and I/O out.
// - External variant maps three serial ports and enable registers.
// - External variant maps ROM, SARAM and external program memory.
`timescale 1ns/10ps
`default_nettype none
module dma_page_map_decode
  import dma_page_map_pkg::*;
#(
  parameter int NUM_PAGES = MAX_PAGES
)(
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        SRST,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Channel source request
  input  wire access_t     SRC_ACC,
  input  wire logic [15:0] SRC_STEP,
  input  wire logic        SRC_DOWN,
  // Channel destination request
  input  wire access_t     DST_ACC,
  input  wire logic [15:0] DST_STEP,
  input  wire logic        DST_DOWN,
  // Decode results
  output decode_t          SRC_DEC,
  output decode_t          DST_DEC,
  output logic      [15:0] SRC_NEXT,
  output logic      [15:0] DST_NEXT
);

  localparam int PAGE_BITS = (NUM_PAGES > MAX_PAGES) ? PAGE_WIDTH :
                             $clog2(NUM_PAGES < 2 ? 2 : NUM_PAGES);
  localparam logic [6:0] PAGE_MASK = 7'((1 << PAGE_BITS) - 1);

  logic [6:0]  src_page;
  logic [6:0]  dst_page;
  logic [3:0]  cfg;
  logic        ph_write;
  logic [7:0]  ph_addr;
  logic        ph_valid;
  decode_t     src_dec_c;
  decode_t     dst_dec_c;
  logic [15:0] next_src;
  logic [15:0] next_dst;
  logic        last_src_refused;
  logic        last_dst_refused;
  logic [6:0]  wr_page;
  logic        wr_src;
  logic        wr_dst;
  logic        wr_cfg;
  logic [6:0]  src_view;
  logic [6:0]  dst_view;
  logic [3:0]  cfg_view;

  // Address phase capture
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr  <= 8'h00;
    end else if (HREADY) begin
      ph_valid <= HSEL && HTRANS[1];
      ph_write <= HWRITE;
      ph_addr  <= HADDR[7:0];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      src_page <= PAGE_RESET[6:0];
      dst_page <= PAGE_RESET[6:0];
    end else if (ph_valid && ph_write) begin
      if (ph_addr == SRC_PAGE_OFFSET)
        src_page <= HWDATA[PAGE_WIDTH-1:PAGE_LSB] & PAGE_MASK;
      if (ph_addr == DST_PAGE_OFFSET)
        dst_page <= HWDATA[PAGE_WIDTH-1:PAGE_LSB] & PAGE_MASK;
    end
  end

  // Variant select and mode bits; mode bits are held but never decoded
  always_ff @(posedge SYS_CLK) begin
    if (SRST)
      cfg <= CFG_RESET;
    else if (ph_valid && ph_write && ph_addr == CONFIG_OFFSET)
      cfg <= HWDATA[3:0];
  end

  // A write still in its data phase is forwarded, so a read issued right
  // behind it returns the new value rather than the old one
  assign wr_page  = HWDATA[PAGE_WIDTH-1:PAGE_LSB] & PAGE_MASK;
  assign wr_src   = ph_valid && ph_write && (ph_addr == SRC_PAGE_OFFSET);
  assign wr_dst   = ph_valid && ph_write && (ph_addr == DST_PAGE_OFFSET);
  assign wr_cfg   = ph_valid && ph_write && (ph_addr == CONFIG_OFFSET);
  assign src_view = wr_src ? wr_page : src_page;
  assign dst_view = wr_dst ? wr_page : dst_page;
  assign cfg_view = wr_cfg ? HWDATA[3:0] : cfg;

  // Read data registered in the address phase so data is ready at once
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      HRDATA <= 32'h0000_0000;
    end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
      case (HADDR[7:0])
        SRC_PAGE_OFFSET: HRDATA <= {25'h0, src_view};
        DST_PAGE_OFFSET: HRDATA <= {25'h0, dst_view};
        CONFIG_OFFSET:   HRDATA <= {28'h0, cfg_view};
        STATUS_OFFSET:   HRDATA <= {30'h0, last_dst_refused,
                                    last_src_refused};
        default:         HRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  dma_map_decode src_decode (
    .page             (src_page),
    .acc              (SRC_ACC),
    .external_variant (cfg[CFG_VARIANT_BIT]),
    .dec              (src_dec_c)
  );

  dma_map_decode dst_decode (
    .page             (dst_page),
    .acc              (DST_ACC),
    .external_variant (cfg[CFG_VARIANT_BIT]),
    .dec              (dst_dec_c)
  );

  dma_addr_step src_step (
    .addr      (SRC_ACC.addr),
    .step      (SRC_STEP),
    .down      (SRC_DOWN),
    .next_addr (next_src)
  );

  dma_addr_step dst_step (
    .addr      (DST_ACC.addr),
    .step      (DST_STEP),
    .down      (DST_DOWN),
    .next_addr (next_dst)
  );

  // Registered decode outputs
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      SRC_DEC  <= '0;
      DST_DEC  <= '0;
      SRC_NEXT <= 16'h0000;
      DST_NEXT <= 16'h0000;
    end else begin
      SRC_DEC  <= src_dec_c;
      DST_DEC  <= dst_dec_c;
      SRC_NEXT <= next_src;
      DST_NEXT <= next_dst;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      last_src_refused <= 1'b0;
      last_dst_refused <= 1'b0;
    end else begin
      last_src_refused <= !src_dec_c.allow;
      last_dst_refused <= !dst_dec_c.allow;
    end
  end

endmodule : dma_page_map_decode
`default_nettype wire

// ### hw/dma_page_map_pkg.sv
// Package: register map, field layout and decode types for the page/map block
package dma_page_map_pkg;

  // Register byte offsets
  localparam logic [7:0] SRC_PAGE_OFFSET = 8'h00;
  localparam logic [7:0] DST_PAGE_OFFSET = 8'h04;
  localparam logic [7:0] CONFIG_OFFSET   = 8'h08;
  localparam logic [7:0] STATUS_OFFSET   = 8'h0C;

  // Page field
  localparam int          PAGE_WIDTH   = 7;
  localparam int          PAGE_LSB     = 0;
  localparam logic [15:0] PAGE_RESET   = 16'h0000;
  localparam int          MAX_PAGES    = 128;

  // Config register fields
  localparam int         CFG_VARIANT_BIT  = 0;
  localparam int         CFG_MODE_BIT     = 1;
  localparam int         CFG_DATA_ROM_BIT = 2;
  localparam int         CFG_OVERLAY_BIT  = 3;
  localparam logic [3:0] CFG_RESET        = 4'h0;

  // Internal-only map, data space
  localparam logic [15:0] SP0_LO     = 16'h0020;
  localparam logic [15:0] SP0_HI     = 16'h0023;
  localparam logic [15:0] SP1_LO     = 16'h0040;
  localparam logic [15:0] SP1_HI     = 16'h0043;
  localparam logic [15:0] SP2_LO     = 16'h0030;
  localparam logic [15:0] SP2_HI     = 16'h0033;
  localparam logic [15:0] SCRATCH_LO = 16'h0060;
  localparam logic [15:0] SCRATCH_HI = 16'h007F;
  localparam logic [15:0] DARAM_LO   = 16'h0800;
  localparam logic [15:0] DARAM_HI   = 16'h3FFF;
  localparam logic [22:0] INT_PROG_TOP = 23'h0F_FFFF;

  // External-capable map
  localparam logic [15:0] CE2_LO     = 16'h0036;
  localparam logic [15:0] CE2_HI     = 16'h0037;
  localparam logic [15:0] CE0_LO     = 16'h003A;
  localparam logic [15:0] CE0_HI     = 16'h003B;
  localparam logic [15:0] CE1_LO     = 16'h004A;
  localparam logic [15:0] CE1_HI     = 16'h004B;
  localparam logic [15:0] ONCHIP_LO  = 16'h0060;
  localparam logic [15:0] ONCHIP_HI  = 16'h7FFF;
  localparam logic [15:0] EXTDATA_LO = 16'h8000;
  localparam logic [22:0] PROG_RSV_HI = 23'h00_007F;
  localparam logic [22:0] ROM_LO     = 23'h00_C000;
  localparam logic [22:0] ROM_HI     = 23'h00_FFFF;
  localparam logic [22:0] SARAM_LO   = 23'h01_8000;
  localparam logic [22:0] SARAM_HI   = 23'h01_FFFF;
  localparam logic [22:0] PROG_TOP   = 23'h7F_FFFF;

  typedef enum logic [1:0] {
    SPACE_PROG = 2'h0,
    SPACE_DATA = 2'h1,
    SPACE_IO   = 2'h2
  } space_t;

  typedef enum logic [2:0] {
    TGT_RESERVED = 3'h0,
    TGT_SERIAL   = 3'h1,
    TGT_INTERNAL = 3'h2,
    TGT_EXTERNAL = 3'h3,
    TGT_ROM      = 3'h4
  } target_t;

  typedef struct packed {
    space_t      space;
    logic [15:0] addr;
  } access_t;

  typedef struct packed {
    logic        allow;
    target_t     target;
    logic [22:0] full_addr;
  } decode_t;

endpackage : dma_page_map_pkg

// ### hw/dma_addr_step.sv
// Address step with wrap inside the 64K page
`timescale 1ns/10ps
`default_nettype none
module dma_addr_step
  import dma_page_map_pkg::*;
(
  // Current address and step
  input  wire logic [15:0] addr,
  input  wire logic [15:0] step,
  input  wire logic        down,
  // Next address
  output logic      [15:0] next_addr
);

  // wrap within page
  // Plain 16-bit arithmetic drops the carry, so the page is never touched
  assign next_addr = down ? 16'(addr - step) : 16'(addr + step);

endmodule : dma_addr_step
`default_nettype wire

// ### hw/dma_map_decode.sv
// Map decoder for both device variants
`timescale 1ns/10ps
`default_nettype none
module dma_map_decode
  import dma_page_map_pkg::*;
(
  // Request
  input  wire logic [6:0]  page,
  input  wire access_t     acc,
  input  wire logic        external_variant,
  // Result
  output decode_t          dec
);

  function automatic logic in_rng(input logic [15:0] a,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  function automatic logic in_prg(input logic [22:0] a,
                                  input logic [22:0] lo,
                                  input logic [22:0] hi);
    in_prg = (a >= lo) && (a <= hi);
  endfunction : in_prg

  logic [22:0] full;
  logic [15:0] a;

  assign full = {page, acc.addr};
  assign a    = acc.addr;

  always_comb begin
    dec.full_addr = full;
    dec.target    = TGT_RESERVED;
    if (!external_variant) begin
      case (acc.space)
        SPACE_PROG: dec.target = TGT_RESERVED;
        SPACE_DATA: begin
          if (in_rng(a, SP0_LO, SP0_HI) || in_rng(a, SP1_LO, SP1_HI))
            dec.target = TGT_SERIAL;
          else if (in_rng(a, SCRATCH_LO, SCRATCH_HI) ||
                   in_rng(a, DARAM_LO, DARAM_HI))
            dec.target = TGT_INTERNAL;
        end
        default: dec.target = TGT_RESERVED;
      endcase
    end else begin
      case (acc.space)
        SPACE_PROG: begin
          if (in_prg(full, ROM_LO, ROM_HI))
            dec.target = TGT_ROM;
          else if (in_prg(full, SARAM_LO, SARAM_HI))
            dec.target = TGT_INTERNAL;
          else if (full > PROG_RSV_HI && full <= PROG_TOP)
            dec.target = TGT_EXTERNAL;
        end
        SPACE_DATA: begin
          if (in_rng(a, SP0_LO, SP0_HI) || in_rng(a, SP1_LO, SP1_HI) ||
              in_rng(a, SP2_LO, SP2_HI) || in_rng(a, CE2_LO, CE2_HI) ||
              in_rng(a, CE0_LO, CE0_HI) || in_rng(a, CE1_LO, CE1_HI))
            dec.target = TGT_SERIAL;
          else if (in_rng(a, ONCHIP_LO, ONCHIP_HI))
            dec.target = TGT_INTERNAL;
          else if (a >= EXTDATA_LO)
            dec.target = TGT_EXTERNAL;
        end
        SPACE_IO: dec.target = TGT_EXTERNAL;
        default:  dec.target = TGT_RESERVED;
      endcase
    end
    dec.allow = (dec.target != TGT_RESERVED);
  end

endmodule : dma_map_decode
`default_nettype wire

// ### dv/dma_page_map_monitor.sv
// Checker for map decode, address stepping and bus answer
`timescale 1ns/10ps
`default_nettype none
module dma_page_map_monitor
  import dma_page_map_pkg::*;
(
  // Clock, reset and bus answer
  input wire logic        SYS_CLK,
  input wire logic        SRST,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  // Requests
  input wire access_t     SRC_ACC,
  input wire logic [15:0] SRC_STEP,
  input wire logic        SRC_DOWN,
  input wire access_t     DST_ACC,
  input wire logic [15:0] DST_STEP,
  input wire logic        DST_DOWN,
  // Results
  input wire decode_t     SRC_DEC,
  input wire decode_t     DST_DEC,
  input wire logic [15:0] SRC_NEXT,
  input wire logic [15:0] DST_NEXT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  logic live;
  // Results just out of reset still carry reset values
  always_ff @(posedge SYS_CLK) begin
    live <= !SRST;
  end
  allow_target_a: assert property (
    SRC_DEC.allow == (SRC_DEC.target != TGT_RESERVED))
    else $error("allow disagrees with target");
  src_concat_a: assert property (
    live |-> SRC_DEC.full_addr[15:0] == $past(SRC_ACC.addr))
    else $error("source low address wrong");
  dst_concat_a: assert property (
    live |-> DST_DEC.full_addr[15:0] == $past(DST_ACC.addr))
    else $error("destination low address wrong");
  src_wrap_a: assert property (
    live |-> SRC_NEXT == ($past(SRC_DOWN) ?
      $past(SRC_ACC.addr) - $past(SRC_STEP) :
      $past(SRC_ACC.addr) + $past(SRC_STEP)))
    else $error("source next address wrong");
  dst_wrap_a: assert property (
    live |-> DST_NEXT == ($past(DST_DOWN) ?
      $past(DST_ACC.addr) - $past(DST_STEP) :
      $past(DST_ACC.addr) + $past(DST_STEP)))
    else $error("destination next address wrong");
  low_prog_a: assert property (
    live && $past(SRC_ACC.space) == SPACE_PROG &&
    SRC_DEC.full_addr[22:7] == 16'h0000 |-> !SRC_DEC.allow)
    else $error("low program space allowed");
  daram_a: assert property (
    live && $past(DST_ACC.space) == SPACE_DATA &&
    $past(DST_ACC.addr) inside {[16'h0800:16'h3FFF]}
    |-> DST_DEC.target == TGT_INTERNAL)
    else $error("dual-access RAM not internal");
  serial_a: assert property (
    live && $past(SRC_ACC.space) == SPACE_DATA &&
    $past(SRC_ACC.addr) inside {[16'h0020:16'h0023]}
    |-> SRC_DEC.target == TGT_SERIAL)
    else $error("serial register not decoded");
  low_data_a: assert property (
    live && $past(DST_ACC.space) == SPACE_DATA &&
    $past(DST_ACC.addr) < 16'h0020 |-> !DST_DEC.allow)
    else $error("low data space allowed");
  bus_okay_a: assert property (
    HREADYOUT && !HRESP)
    else $error("register bus stalled or errored");
  data_ext_a: assert property (
    live && $past(SRC_ACC.space) == SPACE_DATA &&
    $past(SRC_ACC.addr) < 16'h8000 |-> SRC_DEC.target != TGT_EXTERNAL)
    else $error("low data space sent external");
  io_space_a: assert property (
    live && $past(DST_ACC.space) == SPACE_IO
    |-> DST_DEC.target inside {TGT_RESERVED, TGT_EXTERNAL})
    else $error("I/O space decoded on chip");
  rom_c: cover property (SRC_DEC.target == TGT_ROM);
  ext_c: cover property (DST_DEC.target == TGT_EXTERNAL);
  wrap_c: cover property (live && !$past(SRC_DOWN) &&
    SRC_NEXT < $past(SRC_ACC.addr));
endmodule : dma_page_map_monitor
bind dma_page_map_decode dma_page_map_monitor dma_page_map_monitor_inst (
  .SYS_CLK, .SRST, .HREADYOUT, .HRESP, .SRC_ACC, .SRC_STEP, .SRC_DOWN,
  .DST_ACC, .DST_STEP, .DST_DOWN, .SRC_DEC, .DST_DEC, .SRC_NEXT,
  .DST_NEXT);
`default_nettype wire

// ### dv/dma_target_model.sv
// Far-side target model answering decoded accesses
`timescale 1ns/10ps
`default_nettype none
module dma_target_model
  import dma_page_map_pkg::*;
(
  // Clock and decoded access
  input  wire logic    clk,
  input  wire decode_t dec,
  // Returned word
  output logic [15:0]  rd_word
);
  // Refused access leaves the bus undriven, so the word keeps changing
  always_ff @(posedge clk) begin
    if (dec.allow) begin
      rd_word <= dec.full_addr[15:0];
    end else begin
      rd_word <= ~rd_word;
    end
  end
endmodule : dma_target_model
`default_nettype wire

// ### dv/tb_dma_page_map_decode.sv
// Bench for page registers and DMA map decode
`timescale 1ns/10ps
`default_nettype none
module tb_dma_page_map_decode;
  import dma_page_map_pkg::*;
  logic        SYS_CLK, SRST, HSEL, HWRITE, HREADYOUT, HRESP;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  access_t     SRC_ACC, DST_ACC;
  logic [15:0] SRC_STEP, DST_STEP, SRC_NEXT, DST_NEXT, rd_word;
  logic        SRC_DOWN, DST_DOWN;
  decode_t     SRC_DEC, DST_DEC;
  logic [6:0]  sp, dp;
  int          n_errors, check_count, cycles;

  dma_page_map_decode dma_page_map_decode_inst (
    .SYS_CLK, .SRST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .SRC_ACC,
    .SRC_STEP, .SRC_DOWN, .DST_ACC, .DST_STEP, .DST_DOWN, .SRC_DEC,
    .DST_DEC, .SRC_NEXT, .DST_NEXT);
  dma_target_model dma_target_model_inst (.clk(SYS_CLK), .dec(SRC_DEC),
    .rd_word(rd_word));

  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  // Whole run needs well under this many cycles
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge SYS_CLK);
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR  <= {24'h000000, a};
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask : bus

  task automatic dec(input space_t s, input logic [15:0] a,
                     input target_t ts, input target_t td);
    @(posedge SYS_CLK);
    SRC_ACC <= '{s, a};
    DST_ACC <= '{s, a};
    @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    chk(SRC_DEC.target, ts);
    chk(DST_DEC.target, td);
    if (s == SPACE_PROG) begin
      // Program targets carry the page above the address
      chk(SRC_DEC.full_addr, {sp, a});
      chk(DST_DEC.full_addr, {dp, a});
    end
  endtask : dec

  initial begin
    SRST = 1'b1;
    HSEL = 1'b0;
    HADDR = '0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = '0;
    SRC_ACC = '0;
    DST_ACC = '0;
    SRC_STEP = '0;
    DST_STEP = '0;
    SRC_DOWN = 1'b0;
    DST_DOWN = 1'b0;
    n_errors = 0;
    check_count = 0;
    cycles = 0;
    repeat (2) @(posedge SYS_CLK);
    SRST <= 1'b0;
    bus(1'b0, SRC_PAGE_OFFSET, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, DST_PAGE_OFFSET, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, SRC_PAGE_OFFSET, 32'hFFFF_FFFF);
    bus(1'b1, DST_PAGE_OFFSET, 32'h0000_0003);
    bus(1'b0, SRC_PAGE_OFFSET, 32'h0);
    chk(rd, 32'h0000_007F);
    bus(1'b0, DST_PAGE_OFFSET, 32'h0);
    chk(rd, 32'h0000_0003);
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    $display("test registers done");
    sp = 7'h7F;
    dp = 7'h03;
    dec(SPACE_PROG, 16'hC000, TGT_RESERVED, TGT_RESERVED);
    dec(SPACE_IO, 16'h0000, TGT_RESERVED, TGT_RESERVED);
    dec(SPACE_DATA, 16'h0021, TGT_SERIAL, TGT_SERIAL);
    dec(SPACE_DATA, 16'h007F, TGT_INTERNAL, TGT_INTERNAL);
    dec(SPACE_DATA, 16'h3FFF, TGT_INTERNAL, TGT_INTERNAL);
    dec(SPACE_DATA, 16'h4000, TGT_RESERVED, TGT_RESERVED);
    dec(SPACE_DATA, 16'h0036, TGT_RESERVED, TGT_RESERVED);
    bus(1'b1, CONFIG_OFFSET, 32'h0000_000E);
    dec(SPACE_DATA, 16'h0800, TGT_INTERNAL, TGT_INTERNAL);
    dec(SPACE_DATA, 16'h4000, TGT_RESERVED, TGT_RESERVED);
    $display("test internal map done");
    bus(1'b1, CONFIG_OFFSET, 32'h0000_0001);
    bus(1'b1, SRC_PAGE_OFFSET, 32'h0);
    bus(1'b1, DST_PAGE_OFFSET, 32'h0000_0001);
    sp = 7'h00;
    dp = 7'h01;
    dec(SPACE_PROG, 16'hC000, TGT_ROM, TGT_INTERNAL);
    dec(SPACE_PROG, 16'h0010, TGT_RESERVED, TGT_EXTERNAL);
    bus(1'b0, STATUS_OFFSET, 32'h0);
    chk(rd, 32'h0000_0001);
    dec(SPACE_PROG, 16'h8000, TGT_EXTERNAL, TGT_INTERNAL);
    dec(SPACE_DATA, 16'h0036, TGT_SERIAL, TGT_SERIAL);
    dec(SPACE_DATA, 16'h003B, TGT_SERIAL, TGT_SERIAL);
    dec(SPACE_DATA, 16'h004B, TGT_SERIAL, TGT_SERIAL);
    dec(SPACE_DATA, 16'h0038, TGT_RESERVED, TGT_RESERVED);
    dec(SPACE_DATA, 16'h7FFF, TGT_INTERNAL, TGT_INTERNAL);
    dec(SPACE_DATA, 16'h8000, TGT_EXTERNAL, TGT_EXTERNAL);
    dec(SPACE_IO, 16'h1234, TGT_EXTERNAL, TGT_EXTERNAL);
    bus(1'b1, CONFIG_OFFSET, 32'h0000_000F);
    dec(SPACE_PROG, 16'hFFFF, TGT_ROM, TGT_INTERNAL);
    $display("test external map done");
    @(posedge SYS_CLK);
    SRC_ACC <= '{SPACE_PROG, 16'hFFFF};
    DST_ACC <= '{SPACE_PROG, 16'h0001};
    SRC_STEP <= 16'h0001;
    DST_STEP <= 16'h0002;
    DST_DOWN <= 1'b1;
    @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    chk(SRC_NEXT, 16'h0000);
    chk(DST_NEXT, 16'hFFFF);
    chk(DST_DEC.full_addr, {7'h01, 16'h0001});
    @(negedge SYS_CLK);
    chk(rd_word, 16'hFFFF);
    bus(1'b0, DST_PAGE_OFFSET, 32'h0);
    chk(rd, 32'h0000_0001);
    $display("test stepping done");
    @(posedge SYS_CLK);
    SRST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    SRST <= 1'b0;
    bus(1'b0, DST_PAGE_OFFSET, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, CONFIG_OFFSET, 32'h0);
    chk(rd, 32'h0);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule : tb_dma_page_map_decode
`default_nettype wire
